// File: hdl/dtb_top.sv
// data tenure controller: bus ownership, 64-bit data path, lane parity
//
// Contract
// - permit seen at grant lets an outstanding write jump ahead of reads; the code does so only once its first beat is buffered
// - without permit, data tenures follow address tenure order exactly
// - permit is looked at only on a qualified grant edge
// - no write pending at grant: ignore permit, serve next read
// - always take the bus when needed and grant is qualified; the code waits while a write's first beat is not yet buffered
// - busy asserts the cycle after the qualified grant
// - after final ack drive busy negated, then float it
// - busy input asserted means another master owns the bus
// - 64-bit two-way data bus in high and low halves
// - lanes 0-3 in the high half, lanes 4-7 in the low half
// - single beat for noncached, four beats for cache bursts
// - unselected write lanes carry undefined data
// - first write beat with busy, next beat after each ack
// - write data floats the cycle after the final ack
// - one odd parity bit per lane on writes
// - parity lines share the data lines' drive and float timing
// - check all lanes on reads; checkstop when checking enabled
// - grant qualified only with busy, data retry, address retry negated
// - parity error output two cycles after ack unless data retried
`timescale 1ns/1ps
`include "dtb_map.svh"
module dtb_top #(
   parameter int QDEPTH = `DTB_QDEPTH,
   parameter int REL_CYC = `DTB_BUSY_NEG_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input dtb_pkg::dtb_tenure_t tenure_in,
   input wire logic tenure_valid,
   output logic tenure_ready,
   input wire logic [0:63] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [0:63] rd_data,
   output logic rd_valid,
   output logic tenure_done,
   input wire logic data_grant_n,
   input wire logic write_reorder_permit_n,
   input wire logic transfer_ack_n,
   input wire logic data_retry_n,
   input wire logic address_retry_n,
   input wire logic data_tenure_busy_n_in,
   output logic data_tenure_busy_n_out,
   output logic data_tenure_busy_n_oe,
   input wire logic [0:31] data_high_half_in,
   output logic [0:31] data_high_half_out,
   output logic data_high_half_oe,
   input wire logic [0:31] data_low_half_in,
   output logic [0:31] data_low_half_out,
   output logic data_low_half_oe,
   input wire logic [0:7] lane_parity_in,
   output logic [0:7] lane_parity_out,
   output logic lane_parity_oe,
   output logic parity_error_n_out,
   output logic parity_error_n_oe,
   input wire logic parity_check_enable,
   output logic checkstop
);
   import dtb_pkg::*;

   localparam int QI = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
   localparam int QC = $clog2(QDEPTH + 1);

   generate
      if (QDEPTH < 2 || REL_CYC < 1 || REL_CYC > 3) begin : g_bad_param
         $error("dtb_top: QDEPTH must be 2 or more, REL_CYC 1 to 3");
      end
   endgenerate

   // ********************************************************
   // lane parity helpers
   // ********************************************************
   // odd parity per lane: data bits plus parity bit hold an odd count
   function automatic logic [0:7] lane_par(input logic [0:63] d);
      logic [0:7] p;
      p = '0;
      for (int i = 0; i < `DTB_LANES; i++) begin
         p[i] = ~(^d[i*`DTB_LANE_W +: `DTB_LANE_W]);
      end
      return p;
   endfunction

   // a lane is bad when its nine bits xor to zero
   function automatic logic [0:7] lane_err(input logic [0:63] d, input logic [0:7] p);
      logic [0:7] e;
      e = '0;
      for (int i = 0; i < `DTB_LANES; i++) begin
         e[i] = ~(^{d[i*`DTB_LANE_W +: `DTB_LANE_W], p[i]});
      end
      return e;
   endfunction

   // ********************************************************
   // write beat buffer
   // ********************************************************
   dtb_beat_t wr_beat;
   dtb_beat_t head;
   logic head_valid;
   logic head_pop;

   // parity is made at push time so the pins come straight from flops
   assign wr_beat = '{data: wr_data, par: lane_par(wr_data)};

   dtb_buf #(
      .WIDTH($bits(dtb_beat_t)),
      .DEPTH(`DTB_BUF_DEPTH)
   ) i_dtb_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_data(wr_beat),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(head_pop)
   );

   // lanes 0-3 on the high half, 4-7 on the low half; whatever the core
   // put in unselected lanes goes out as is
   assign data_high_half_out = head.data[0:31];
   assign data_low_half_out = head.data[32:63];
   assign lane_parity_out = head.par;

   // ********************************************************
   // bus qualification
   // ********************************************************
   logic ta;
   logic qgrant;
   dtb_state_t state;

   assign ta = ~transfer_ack_n;
   // a busy input low from anyone keeps us off the bus
   assign qgrant = ~data_grant_n & data_tenure_busy_n_in & data_retry_n
      & address_retry_n;

   // ********************************************************
   // pending tenure queue, oldest in slot zero
   // ********************************************************
   dtb_tenure_t q [QDEPTH];
   dtb_tenure_t next_q [QDEPTH];
   logic [QC-1:0] q_cnt;
   logic [QC-1:0] next_cnt;
   logic next_tenure_ready;
   logic [QI-1:0] sel;
   logic wr_found;
   logic [QI-1:0] wr_idx;
   dtb_tenure_t pick;
   logic take;

   // oldest write, and which slot the grant will serve
   always_comb begin
      wr_found = 1'b0;
      wr_idx = '0;
      for (int i = QDEPTH - 1; i >= 0; i--) begin
         if (QC'(i) < q_cnt && q[i].write) begin
            wr_found = 1'b1;
            wr_idx = QI'(i);
         end
      end
      // permit counts only here, on the qualified grant; no pending write
      // (or no data for it yet) falls back to the oldest tenure
      if (qgrant && ~write_reorder_permit_n && wr_found && head_valid) begin
         sel = wr_idx;
      end else begin
         sel = '0;
      end
      pick = q[sel];
      // a write without its first beat would stall the bus, so wait
      take = (state == ST_IDLE) && qgrant && (q_cnt != '0)
         && (!pick.write || head_valid);
   end

   // remove the served slot, close the gap, append the new tenure
   always_comb begin
      next_cnt = q_cnt;
      for (int i = 0; i < QDEPTH; i++) begin
         if (take && QI'(i) >= sel && i < QDEPTH - 1) begin
            next_q[i] = q[i+1];
         end else begin
            next_q[i] = q[i];
         end
      end
      if (take) begin
         next_cnt = q_cnt - QC'(1);
      end
      if (tenure_valid && tenure_ready) begin
         next_q[next_cnt[QI-1:0]] = tenure_in;
         next_cnt = next_cnt + QC'(1);
      end
      next_tenure_ready = next_cnt < QC'(QDEPTH);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q_cnt <= '0;
         tenure_ready <= 1'b0;
         for (int i = 0; i < QDEPTH; i++) begin
            q[i] <= '0;
         end
      end else begin
         q_cnt <= next_cnt;
         tenure_ready <= next_tenure_ready;
         q <= next_q;
      end
   end

   // ********************************************************
   // data tenure sequencer and read path
   // ********************************************************
   dtb_state_t next_state;
   logic [1:0] beats_left;
   logic [1:0] next_beats_left;
   logic [1:0] rel_cnt;
   logic [1:0] next_rel_cnt;
   logic drive;
   logic next_drive;
   logic busy_oe;
   logic next_busy_oe;
   logic busy_n;
   logic next_busy_n;
   logic cap_v;
   logic next_cap_v;
   logic cap_err;
   logic next_cap_err;
   logic [0:63] cap_data;
   logic [0:63] next_cap_data;
   logic [0:63] next_rd_data;
   logic next_rd_valid;
   logic next_perr;
   logic next_checkstop;
   logic next_done;
   logic perr_oe;
   logic final_ta;

   assign final_ta = ta && (beats_left == 2'd0);
   assign head_pop = (state == ST_WRITE) && ta;

   always_comb begin
      next_state = state;
      next_beats_left = beats_left;
      next_rel_cnt = rel_cnt;
      next_drive = drive;
      next_busy_oe = busy_oe;
      next_busy_n = busy_n;
      next_done = 1'b0;
      next_cap_v = 1'b0;
      next_cap_err = 1'b0;
      next_cap_data = cap_data;
      case (state)
         ST_IDLE: begin
            if (take) begin
               // busy and first write beat land together, one cycle on
               next_busy_n = 1'b0;
               next_busy_oe = 1'b1;
               next_drive = pick.write;
               next_beats_left = pick.burst ? 2'(`DTB_BURST_BEATS - 1)
                  : 2'(`DTB_SINGLE_BEATS - 1);
               next_state = pick.write ? ST_WRITE : ST_READ;
            end
         end
         ST_WRITE, ST_READ: begin
            if (state == ST_READ && ta) begin
               // responder's data is valid with its ack; check every lane
               next_cap_v = 1'b1;
               next_cap_data = {data_high_half_in, data_low_half_in};
               next_cap_err = |lane_err({data_high_half_in, data_low_half_in},
                  lane_parity_in);
            end
            if (ta) begin
               next_beats_left = beats_left - 2'd1;
            end
            if (final_ta) begin
               next_drive = 1'b0;
               next_busy_n = 1'b1;
               next_rel_cnt = 2'(REL_CYC - 1);
               next_done = 1'b1;
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // negated for a full cycle covers the half-cycle minimum
            if (rel_cnt == 2'd0) begin
               next_busy_oe = 1'b0;
               next_state = ST_IDLE;
            end else begin
               next_rel_cnt = rel_cnt - 2'd1;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_drive = 1'b0;
            next_busy_oe = 1'b0;
            next_busy_n = 1'b1;
         end
      endcase
      // a retry in the cycle after the ack withdraws the beat and its error
      next_rd_valid = cap_v & data_retry_n;
      next_rd_data = cap_v ? cap_data : rd_data;
      next_perr = cap_v & cap_err & data_retry_n;
      next_checkstop = checkstop | (next_perr & parity_check_enable);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         beats_left <= 2'd0;
         rel_cnt <= 2'd0;
         drive <= 1'b0;
         busy_oe <= 1'b0;
         busy_n <= 1'b1;
         cap_v <= 1'b0;
         cap_err <= 1'b0;
         cap_data <= `DTB_RST_DATA;
         rd_data <= `DTB_RST_DATA;
         rd_valid <= 1'b0;
         perr_oe <= 1'b0;
         checkstop <= 1'b0;
         tenure_done <= 1'b0;
      end else begin
         state <= next_state;
         beats_left <= next_beats_left;
         rel_cnt <= next_rel_cnt;
         drive <= next_drive;
         busy_oe <= next_busy_oe;
         busy_n <= next_busy_n;
         cap_v <= next_cap_v;
         cap_err <= next_cap_err;
         cap_data <= next_cap_data;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         perr_oe <= next_perr;
         checkstop <= next_checkstop;
         tenure_done <= next_done;
      end
   end

   // one enable flop feeds data and parity alike, so they cannot drift
   assign data_high_half_oe = drive;
   assign data_low_half_oe = drive;
   assign lane_parity_oe = drive;
   assign data_tenure_busy_n_out = busy_n;
   assign data_tenure_busy_n_oe = busy_oe;
   // open-drain: only ever pulls low, enable carries the pulse
   assign parity_error_n_out = 1'b0;
   assign parity_error_n_oe = perr_oe;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   chk_busy_after_grant: assert property (take |=> !busy_n && busy_oe)
      else $error("busy not driven the cycle after a qualified grant");
   chk_write_first_beat: assert property (take && pick.write |=> drive && !busy_n)
      else $error("first write beat not presented with busy");
   chk_write_release: assert property (state == ST_WRITE && final_ta
      |=> (!drive && busy_n && busy_oe) ##1 !busy_oe)
      else $error("write release sequence wrong after final ack");
   chk_parity_odd: assert property (drive |-> lane_err(head.data, head.par) == 8'h00)
      else $error("driven lane parity is not odd");
   chk_parity_follows: assert property ($rose(drive) |-> $rose(lane_parity_oe)
      && $rose(data_low_half_oe))
      else $error("parity enable not in step with data enable");
   chk_perr_timing: assert property ((state == ST_READ && ta && |lane_err({data_high_half_in,
      data_low_half_in}, lane_parity_in)) ##1 data_retry_n |=> perr_oe ##1 !perr_oe)
      else $error("parity error not signalled two cycles after ack");
   chk_perr_cancel: assert property ((state == ST_READ && ta) ##1 !data_retry_n
      |=> !perr_oe && !rd_valid)
      else $error("retried beat still flagged or delivered");
   chk_order_strict: assert property (take && write_reorder_permit_n |-> sel == '0)
      else $error("tenure served out of order without permit");
   chk_busy_input: assert property (state == ST_IDLE && !data_tenure_busy_n_in
      |=> !busy_oe && !drive)
      else $error("bus taken while another master holds busy");
   chk_checkstop_set: assert property (perr_oe && parity_check_enable |=> checkstop)
      else $error("checkstop missing after enabled parity error");

   cov_write_burst: cover property (take && pick.write && pick.burst);
   cov_read_single: cover property (take && !pick.write && !pick.burst);
   cov_reorder: cover property (take && sel != '0);
   cov_parity_err: cover property (perr_oe);

endmodule // dtb_top

// File: hdl/dtb_map.svh
// constants for the data tenure block: counts, timings, reset values
`ifndef DTB_MAP_SVH
`define DTB_MAP_SVH

// ********************************************************
// widths and depths
// ********************************************************
`define DTB_DATA_W 64
`define DTB_LANES 8
`define DTB_LANE_W 8
`define DTB_QDEPTH 4
`define DTB_BUF_DEPTH 2

// ********************************************************
// beats per tenure
// ********************************************************
`define DTB_SINGLE_BEATS 1
`define DTB_BURST_BEATS 4

// ********************************************************
// timing: busy is driven negated for at least half a bus cycle
// ********************************************************
`define DTB_CLK_PERIOD_PS 10000
`define DTB_BUSY_NEG_MIN_PS 5000
`define DTB_BUSY_NEG_CYC \
   ((`DTB_BUSY_NEG_MIN_PS + `DTB_CLK_PERIOD_PS - 1) / `DTB_CLK_PERIOD_PS)

// ********************************************************
// reset values
// ********************************************************
`define DTB_RST_DATA 64'h0000_0000_0000_0000
`define DTB_RST_PAR 8'hff

`endif

// File: hdl/dtb_pkg.sv
// types shared by the data tenure block
package dtb_pkg;

   // ********************************************************
   // tenure controller states
   // ********************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WRITE,
      ST_READ,
      ST_RELEASE
   } dtb_state_t;

   // one address tenure already issued, awaiting its data tenure
   typedef struct packed {
      logic write;
      logic burst;
   } dtb_tenure_t;

   // one data beat as it sits on the pins, parity included
   typedef struct packed {
      logic [0:63] data;
      logic [0:7] par;
   } dtb_beat_t;

endpackage

// File: hdl/dtb_buf.sv
// shift-register buffer: head entry is always slot zero
`timescale 1ns/1ps
module dtb_buf #(
   parameter int WIDTH = 72,
   parameter int DEPTH = 2
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   import dtb_pkg::*;

   // ********************************************************
   // storage
   // ********************************************************
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [DEPTH-1:0] vld;
   logic [DEPTH-1:0] next_vld;
   logic push;
   logic pop;
   logic [DEPTH-1:0] kept;

   generate
      if (DEPTH < 2) begin : g_bad_depth
         $error("dtb_buf needs at least two entries");
      end
   endgenerate

   // head and fullness come straight from flops
   assign out_data = mem[0];
   assign out_valid = vld[0];
   assign in_ready = ~vld[DEPTH-1];
   assign push = in_valid & ~vld[DEPTH-1];
   assign pop = out_ready & vld[0];

   // shift down on pop, then write into the first free slot
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         if (pop && i < DEPTH - 1) begin
            next_mem[i] = mem[i+1];
            next_vld[i] = vld[i+1];
         end else if (pop) begin
            next_mem[i] = mem[i];
            next_vld[i] = 1'b0;
         end else begin
            next_mem[i] = mem[i];
            next_vld[i] = vld[i];
         end
      end
      // judge free slots on the shifted state only, else one push fills them all
      kept = next_vld;
      for (int i = 0; i < DEPTH; i++) begin
         if (push && !kept[i] && (i == 0 || kept[(i > 0) ? i - 1 : 0])) begin
            next_mem[i] = in_data;
            next_vld[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         vld <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         vld <= next_vld;
         mem <= next_mem;
      end
   end

endmodule // dtb_buf

// File: verif/dtb_far_model.sv
// far side model: arbiter grants, acks, read data with parity
`timescale 1ns/1ps
module dtb_far_model (
   input wire logic mclk,
   input dtb_pkg::dtb_beat_t bus,
   input wire logic bus_oe,
   output logic data_grant_n,
   output logic write_reorder_permit_n,
   output logic transfer_ack_n,
   output logic data_retry_n,
   output logic address_retry_n,
   output logic other_busy,
   output dtb_pkg::dtb_beat_t drv
);
   import dtb_pkg::*;
   logic driving;
   int n;
   dtb_beat_t seen [0:3];
   logic seen_oe [0:3];

   // ****************************************
   // idle lines and beat capture
   // ****************************************
   // released lines never hold the last value, so stale data shows
   initial begin
      driving = 1'b0;
      drv = '0;
      n = 0;
      data_grant_n = 1'b1;
      write_reorder_permit_n = 1'b0;
      transfer_ack_n = 1'b1;
      data_retry_n = 1'b1;
      address_retry_n = 1'b1;
      other_busy = 1'b0;
   end
   always @(posedge mclk) if (!driving) drv <= #2 ~drv;
   // each acked beat is recorded as the pins showed it
   always @(posedge mclk) begin
      if (!transfer_ack_n && n < 4) begin
         seen[n] <= bus;
         seen_oe[n] <= bus_oe;
         n <= n + 1;
      end
   end

   // odd parity per lane, lane i = bits i*8..i*8+7
   function automatic logic [0:7] opar(input logic [0:63] d);
      for (int i = 0; i < 8; i++) opar[i] = ~^d[i*8 +: 8];
   endfunction

   // one grant cycle; permit stays asserted between grants
   task automatic grant(input logic pn, input logic ob, input logic ar);
      @(negedge mclk);
      data_grant_n = 1'b0;
      write_reorder_permit_n = pn;
      other_busy = ob;
      address_retry_n = ~ar;
      n = 0;
      @(negedge mclk);
      data_grant_n = 1'b1;
      write_reorder_permit_n = 1'b0;
      other_busy = 1'b0;
      address_retry_n = 1'b1;
   endtask

   // acks with gap wait cycles; read data rides with each ack
   task automatic acks(input int beats, input int gap, input logic rdt,
                       input logic [0:63] rd, input logic [0:7] flip, input logic retry);
      for (int k = 0; k < beats; k++) begin
         if (gap > 0) begin
            transfer_ack_n = 1'b1;
            driving = 1'b0;
            repeat (gap) @(negedge mclk);
         end
         transfer_ack_n = 1'b0;
         driving = rdt;
         if (rdt) drv = {rd, opar(rd) ^ flip};
         @(negedge mclk);
      end
      transfer_ack_n = 1'b1;
      driving = 1'b0;
      data_retry_n = ~retry;
   endtask

   task automatic rel();
      data_retry_n = 1'b1;
   endtask
endmodule // dtb_far_model

// File: verif/dtb_top_bench.sv
// testbench for the data tenure controller
`timescale 1ns/1ps
module dtb_top_bench;
   import dtb_pkg::*;
   logic mclk, rst_n, tenure_valid, tenure_ready, wr_valid, wr_ready, rd_valid, tenure_done;
   logic grant_n, permit_n, ack_n, dretry_n, aretry_n, other_busy, busy_n_in, busy_n_out;
   logic busy_oe, dh_oe, dl_oe, par_oe, perr_n_out, perr_oe, pce, checkstop;
   logic [0:63] wr_data, rd_data;
   logic [0:31] dh_out, dl_out;
   logic [0:7] par_out;
   dtb_tenure_t tenure_in;
   dtb_beat_t drv, bus;
   int fail_count, cmp_count;

   // ****************************************
   // wiring, clock, partner
   // ****************************************
   // pull-up on busy; any driver low wins
   assign busy_n_in = !((busy_oe && !busy_n_out) || other_busy);
   assign bus = {dh_oe ? dh_out : drv.data[0:31], dl_oe ? dl_out : drv.data[32:63],
                 par_oe ? par_out : drv.par};
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   dtb_top i_dtb_top (.mclk(mclk), .rst_n(rst_n), .tenure_in(tenure_in),
      .tenure_valid(tenure_valid), .tenure_ready(tenure_ready), .wr_data(wr_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .tenure_done(tenure_done), .data_grant_n(grant_n), .write_reorder_permit_n(permit_n),
      .transfer_ack_n(ack_n), .data_retry_n(dretry_n), .address_retry_n(aretry_n),
      .data_tenure_busy_n_in(busy_n_in), .data_tenure_busy_n_out(busy_n_out),
      .data_tenure_busy_n_oe(busy_oe), .data_high_half_in(bus.data[0:31]),
      .data_high_half_out(dh_out), .data_high_half_oe(dh_oe),
      .data_low_half_in(bus.data[32:63]), .data_low_half_out(dl_out),
      .data_low_half_oe(dl_oe), .lane_parity_in(bus.par), .lane_parity_out(par_out),
      .lane_parity_oe(par_oe), .parity_error_n_out(perr_n_out),
      .parity_error_n_oe(perr_oe), .parity_check_enable(pce), .checkstop(checkstop));
   dtb_far_model i_dtb_far_model (.mclk(mclk), .bus(bus), .bus_oe(dh_oe),
      .data_grant_n(grant_n), .write_reorder_permit_n(permit_n), .transfer_ack_n(ack_n),
      .data_retry_n(dretry_n), .address_retry_n(aretry_n), .other_busy(other_busy),
      .drv(drv));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // write beat k: byte parities alternate so lane order shows
   function automatic logic [0:63] wb(input int k);
      return 64'h0103070f1f3f7fff ^ {8{8'(k)}};
   endfunction
   // offer a tenure (sel 0) or a write beat (sel 1) once ready allows
   task automatic push(input logic sel, input dtb_tenure_t t, input logic [0:63] d);
      int i;
      @(negedge mclk);
      for (i = 0; i < 50 && (sel ? wr_ready : tenure_ready) !== 1'b1; i++) @(negedge mclk);
      chk(sel ? wr_ready : tenure_ready, 1);
      wr_valid = sel;
      tenure_valid = !sel;
      wr_data = d;
      tenure_in = t;
      @(negedge mclk);
      wr_valid = 1'b0;
      tenure_valid = 1'b0;
   endtask
   // one tenure from grant to release, judged cycle by cycle
   task automatic run(input logic wr, input int beats, input int gap, input logic pn,
                      input logic [0:7] flip, input logic retry);
      i_dtb_far_model.grant(pn, 1'b0, 1'b0);
      chk(busy_oe, 1);
      chk(busy_n_out, 0);
      chk({dh_oe, dl_oe, par_oe}, {3{wr}});
      i_dtb_far_model.acks(beats, gap, !wr, 64'h8142_a5c3_0f00_ff18, flip, retry);
      chk({dh_oe, dl_oe, par_oe}, 0);
      chk({busy_oe, busy_n_out, tenure_done}, 3'b111);
      @(negedge mclk);
      i_dtb_far_model.rel();
      chk(busy_oe, 0);
      chk(rd_valid, !wr && !retry);
      chk({perr_oe, perr_n_out}, {!wr && flip != 0 && !retry, 1'b0});
      if (!wr && !retry) chk(rd_data, 64'h8142_a5c3_0f00_ff18);
      for (int k = 0; k < beats && wr; k++) begin
         chk(i_dtb_far_model.seen[k], {wb(k), i_dtb_far_model.opar(wb(k))});
         chk(i_dtb_far_model.seen_oe[k], 1);
      end
      @(negedge mclk);
      chk(perr_oe, 0);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_write();
      push(0, '{1, 0}, 0);
      push(1, 0, wb(0));
      run(1, 1, 0, 1, 0, 0);
      push(0, '{1, 1}, 0);
      push(1, 0, wb(0));
      push(1, 0, wb(1));
      chk(wr_ready, 0);
      // the far side stalls three cycles per beat while refills arrive
      fork
         run(1, 4, 3, 1, 0, 0);
         begin
            push(1, 0, wb(2));
            push(1, 0, wb(3));
         end
      join
   endtask
   task automatic t_order();
      push(0, '{0, 0}, 0);
      push(0, '{1, 0}, 0);
      push(1, 0, wb(0));
      run(0, 1, 0, 1, 0, 0);
      run(1, 1, 0, 1, 0, 0);
      push(0, '{0, 0}, 0);
      push(0, '{1, 0}, 0);
      push(1, 0, wb(0));
      run(1, 1, 0, 0, 0, 0);
      run(0, 1, 0, 0, 0, 0);
   endtask
   task automatic t_full();
      repeat (4) push(0, '{0, 0}, 0);
      chk(tenure_ready, 0);
      repeat (4) run(0, 1, 0, 0, 0, 0);
      push(0, '{0, 1}, 0);
      run(0, 4, 0, 0, 0, 0);
   endtask
   task automatic t_block();
      push(0, '{0, 0}, 0);
      i_dtb_far_model.grant(1, 1, 0);
      chk(busy_oe, 0);
      i_dtb_far_model.grant(1, 0, 1);
      chk(busy_oe, 0);
      run(0, 1, 0, 1, 0, 0);
   endtask
   task automatic t_parity();
      push(0, '{0, 0}, 0);
      run(0, 1, 0, 1, 8'h20, 0);
      chk(checkstop, 0);
      push(0, '{0, 0}, 0);
      run(0, 1, 0, 1, 8'h20, 1);
      pce = 1'b1;
      push(0, '{0, 0}, 0);
      run(0, 1, 0, 1, 8'h01, 0);
      chk(checkstop, 1);
   endtask

   // whole run is under two hundred cycles
   initial begin
      #100000;
      fail_count++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      tenure_valid = 1'b0;
      tenure_in = '0;
      wr_valid = 1'b0;
      wr_data = '0;
      pce = 1'b0;
      repeat (5) @(negedge mclk);
      chk({busy_oe, dh_oe, dl_oe, par_oe, perr_oe, busy_n_out, rd_valid, checkstop},
          8'h04);
      rst_n = 1'b1;
      t_write();
      t_order();
      t_full();
      t_block();
      t_parity();
      end_sim();
   end
endmodule // dtb_top_bench
